// ---- rtl/r2c_ctrl_regs.svh ----
// Register offsets, field positions, reset values and scale constants for regulator two control
`ifndef R2C_CTRL_REGS_SVH
`define R2C_CTRL_REGS_SVH

`define R2C_ADDR_PEAK        8'h2a
`define R2C_ADDR_VSET        8'h2b
`define R2C_ADDR_MASK        8'h2c
`define R2C_ADDR_PAIR        8'h2d

`define R2C_RST_PEAK         8'h00
`define R2C_RST_VSET         6'h00
`define R2C_RST_MASK         8'h00
`define R2C_RST_PAIR         5'h00

`define R2C_PEAK_BYPASS_BIT  7
`define R2C_PEAK_CODE_MSB    3
`define R2C_VSET_MSB         5
`define R2C_PAIR_MSB         4

`define R2C_PEAK_STEP_MA     9'h019
`define R2C_VOUT_BASE_MV     13'h0226

`define R2C_SEQ_BY_SOURCE    3'h7
`define R2C_SRC_OFF          2'h0
`define R2C_SRC_ON           2'h1
`define R2C_SRC_PIN          2'h2
`define R2C_SRC_RSVD         2'h3

`define R2C_PAIR_OFF         5'h00
`define R2C_PAIR_LAST        5'h1c

`endif

// ---- rtl/r2c_pkg.sv ----
// Types shared by the regulator two control block
package r2c_pkg;
  `include "r2c_ctrl_regs.svh"

  typedef logic [7:0]       r2c_byte_type;
  typedef logic [5:0]       r2c_code6_type;
  typedef logic [3:0]       r2c_code4_type;
  typedef logic [8:0]       r2c_ma_type;
  typedef logic [12:0]      r2c_mv_type;
  typedef logic [3:0][5:0]  r2c_alt_type;

  typedef enum logic [1:0] {
    R2C_SRC_OFF_E  = `R2C_SRC_OFF,
    R2C_SRC_ON_E   = `R2C_SRC_ON,
    R2C_SRC_PIN_E  = `R2C_SRC_PIN,
    R2C_SRC_RSVD_E = `R2C_SRC_RSVD
  } r2c_src_type;
endpackage

// ---- rtl/r2c_pair_if.sv ----
// Pin pair selection signals between the control top and the pair decoder
`timescale 1ns/100ps
interface r2c_pair_if;
  logic [4:0] selector;
  logic [7:0] pins;
  logic       active;
  logic [1:0] state;

  modport decoder (input selector, input pins, output active, output state);
  modport user    (output selector, output pins, input active, input state);
endinterface

// ---- rtl/r2c_pair_decode.sv ----
// Pin pair decoder for dynamic voltage scaling
`timescale 1ns/100ps
`include "r2c_ctrl_regs.svh"
module r2c_pair_decode (
  r2c_pair_if.decoder pair
);
  import r2c_pkg::*;

  // Returns {valid, low pin, high pin}; pairs counted lexicographically
  function automatic logic [6:0] pair_of(input logic [4:0] code);
    logic [4:0] idx;
    logic [6:0] res;
    idx = 5'h00;
    res = 7'h00;
    for (int lo = 0; lo < 7; lo++) begin
      for (int hi = lo + 1; hi < 8; hi++) begin
        idx = idx + 5'h01;
        if (idx == code) begin
          res = {1'b1, 3'(lo), 3'(hi)};
        end
      end
    end
    return res;
  endfunction

  wire [6:0] pair_w  = pair_of(pair.selector);
  wire [2:0] lo_pin  = pair_w[5:3];
  wire [2:0] hi_pin  = pair_w[2:0];

  // Code zero and reserved codes never match, so scaling stays off
  assign pair.active = pair_w[6] && (pair.selector != `R2C_PAIR_OFF);
  // Lower pin is the more significant select bit
  assign pair.state  = {pair.pins[lo_pin], pair.pins[hi_pin]};
endmodule

// ---- rtl/r2c_ctrl.sv ----
// Regulator two control registers: peak current, voltage setpoint, pin enable mask, pair select
`timescale 1ns/100ps
`include "r2c_ctrl_regs.svh"
module r2c_ctrl (
  input  wire logic                   clock,
  input  wire logic                   reset,
  input  wire r2c_pkg::r2c_byte_type  reg_addr,
  input  wire logic                   reg_write,
  input  wire logic                   reg_read,
  input  wire r2c_pkg::r2c_byte_type  reg_wdata,
  output      r2c_pkg::r2c_byte_type  reg_rdata,
  output      logic                   reg_ack,
  input  wire r2c_pkg::r2c_byte_type  multipurpose_control_pin,
  input  wire logic [2:0]             startup_sequence_slot,
  input  wire r2c_pkg::r2c_src_type   enable_source_select,
  input  wire logic                   boot_delay_done,
  input  wire r2c_pkg::r2c_code4_type lookup_peak_code,
  input  wire r2c_pkg::r2c_code6_type voltage_step_size,
  input  wire r2c_pkg::r2c_alt_type   alternate_voltage_setting,
  output      r2c_pkg::r2c_code4_type effective_peak_code,
  output      r2c_pkg::r2c_ma_type    peak_current_ma,
  output      r2c_pkg::r2c_code6_type output_voltage_code,
  output      r2c_pkg::r2c_mv_type    output_voltage_mv,
  output      logic                   pin_mask_active,
  output      logic                   regulator_enable,
  output      logic                   dynamic_voltage_scaling,
  output      logic [1:0]             scaling_pair_state
);
  import r2c_pkg::*;

  function automatic logic addr_is(input r2c_byte_type addr, input r2c_byte_type offs);
    return addr == offs;
  endfunction

  // Registers
  r2c_byte_type  peak_current_control_ff;
  r2c_code6_type output_voltage_setpoint_ff;
  r2c_byte_type  pin_enable_mask_ff;
  logic [4:0]    scaling_pin_pair_select_ff;

  // Outputs
  r2c_byte_type  reg_rdata_ff;
  logic          reg_ack_ff;
  r2c_code4_type effective_peak_code_ff;
  r2c_ma_type    peak_current_ma_ff;
  r2c_code6_type output_voltage_code_ff;
  r2c_mv_type    output_voltage_mv_ff;
  logic          pin_mask_active_ff;
  logic          regulator_enable_ff;
  logic          dvs_ff;
  logic [1:0]    scaling_pair_state_ff;

  // Pin synchronisers; the first stage feeds only the second
  r2c_byte_type  pin_meta_ff;
  r2c_byte_type  pin_sync_ff;

  r2c_pair_if pair_bus ();

  r2c_pair_decode i_r2c_pair_decode (
    .pair (pair_bus.decoder)
  );

  assign pair_bus.selector = scaling_pin_pair_select_ff;
  assign pair_bus.pins     = pin_sync_ff;

  // Address decode
  wire hit_peak = addr_is(reg_addr, `R2C_ADDR_PEAK);
  wire hit_vset = addr_is(reg_addr, `R2C_ADDR_VSET);
  wire hit_mask = addr_is(reg_addr, `R2C_ADDR_MASK);
  wire hit_pair = addr_is(reg_addr, `R2C_ADDR_PAIR);

  // Reserved bits read as zero; unmapped offsets read zero
  r2c_byte_type rd_mux;
  assign rd_mux = hit_peak ? peak_current_control_ff :
                  hit_vset ? {2'h0, output_voltage_setpoint_ff} :
                  hit_mask ? pin_enable_mask_ff :
                  hit_pair ? {3'h0, scaling_pin_pair_select_ff} :
                             8'h00;

  wire [7:0] peak_wr = {reg_wdata[`R2C_PEAK_BYPASS_BIT], 3'h0,
                        reg_wdata[`R2C_PEAK_CODE_MSB:0]};

  // Peak current source selection
  wire           peak_bypass = peak_current_control_ff[`R2C_PEAK_BYPASS_BIT];
  wire [3:0]     peak_prog   = peak_current_control_ff[`R2C_PEAK_CODE_MSB:0];
  r2c_code4_type peak_sel;
  assign peak_sel = peak_bypass ? peak_prog : lookup_peak_code;
  r2c_ma_type    peak_ma;
  assign peak_ma  = 9'(peak_sel) * `R2C_PEAK_STEP_MA;

  // Output voltage: setpoint or alternate setting under scaling
  r2c_code6_type vcode_sel;
  assign vcode_sel = pair_bus.active ? alternate_voltage_setting[pair_bus.state]
                                     : output_voltage_setpoint_ff;
  r2c_mv_type    vout_mv;
  assign vout_mv = `R2C_VOUT_BASE_MV + 13'(vcode_sel) * 13'(voltage_step_size);

  // Enable path
  wire by_source  = (startup_sequence_slot == `R2C_SEQ_BY_SOURCE) && boot_delay_done;
  wire src_pins   = (enable_source_select == R2C_SRC_PIN_E);
  wire src_on     = (enable_source_select == R2C_SRC_ON_E);
  wire mask_apply = by_source && src_pins;
  // OR of masked pins; unmasked pins cannot turn the regulator on
  wire pins_or    = |(pin_enable_mask_ff & pin_sync_ff);
  // Reserved source code and slot values other than 111 keep this path off
  wire enable_nxt = by_source && (src_on || (src_pins && pins_or));

  always_ff @(posedge clock) begin
    if (reset) begin
      pin_meta_ff <= 8'h00;
      pin_sync_ff <= 8'h00;
    end else begin
      pin_meta_ff <= multipurpose_control_pin;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      peak_current_control_ff    <= `R2C_RST_PEAK;
      output_voltage_setpoint_ff <= `R2C_RST_VSET;
      pin_enable_mask_ff         <= `R2C_RST_MASK;
      scaling_pin_pair_select_ff <= `R2C_RST_PAIR;
    end else if (reg_write) begin
      if (hit_peak) begin
        peak_current_control_ff <= peak_wr;
      end else if (hit_vset) begin
        output_voltage_setpoint_ff <= reg_wdata[`R2C_VSET_MSB:0];
      end else if (hit_mask) begin
        pin_enable_mask_ff <= reg_wdata;
      end else if (hit_pair) begin
        scaling_pin_pair_select_ff <= reg_wdata[`R2C_PAIR_MSB:0];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      reg_rdata_ff <= 8'h00;
      reg_ack_ff   <= 1'b0;
    end else begin
      reg_rdata_ff <= reg_read ? rd_mux : 8'h00;
      reg_ack_ff   <= reg_read || reg_write;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      effective_peak_code_ff <= 4'h0;
      peak_current_ma_ff     <= 9'h000;
      output_voltage_code_ff <= 6'h00;
      output_voltage_mv_ff   <= `R2C_VOUT_BASE_MV;
    end else begin
      effective_peak_code_ff <= peak_sel;
      peak_current_ma_ff     <= peak_ma;
      output_voltage_code_ff <= vcode_sel;
      output_voltage_mv_ff   <= vout_mv;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      pin_mask_active_ff    <= 1'b0;
      regulator_enable_ff   <= 1'b0;
      dvs_ff                <= 1'b0;
      scaling_pair_state_ff <= 2'h0;
    end else begin
      pin_mask_active_ff    <= mask_apply;
      regulator_enable_ff   <= enable_nxt;
      dvs_ff                <= pair_bus.active;
      scaling_pair_state_ff <= pair_bus.active ? pair_bus.state : 2'h0;
    end
  end

  assign reg_rdata               = reg_rdata_ff;
  assign reg_ack                 = reg_ack_ff;
  assign effective_peak_code     = effective_peak_code_ff;
  assign peak_current_ma         = peak_current_ma_ff;
  assign output_voltage_code     = output_voltage_code_ff;
  assign output_voltage_mv       = output_voltage_mv_ff;
  assign pin_mask_active         = pin_mask_active_ff;
  assign regulator_enable        = regulator_enable_ff;
  assign dynamic_voltage_scaling = dvs_ff;
  assign scaling_pair_state      = scaling_pair_state_ff;

  // Checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  // Helpers so that each $past sees a plain signal
  wire       on_by_source = by_source && src_on;
  wire [1:0] pins_01      = {pin_sync_ff[0], pin_sync_ff[1]};
  wire [1:0] pins_12      = {pin_sync_ff[1], pin_sync_ff[2]};
  wire [5:0] alt_now      = alternate_voltage_setting[pair_bus.state];
  wire [5:0] wdata_vset   = reg_wdata[`R2C_VSET_MSB:0];

  property p_table_source;
    !peak_bypass |=> effective_peak_code == $past(lookup_peak_code);
  endproperty
  a_table_source: assert property (p_table_source)
    else $error("peak code not taken from lookup table");

  property p_bypass_source;
    peak_bypass |=> effective_peak_code == $past(peak_prog);
  endproperty
  a_bypass_source: assert property (p_bypass_source)
    else $error("peak code not taken from programmed field");

  property p_peak_scale;
    peak_current_ma == 9'(effective_peak_code) * `R2C_PEAK_STEP_MA;
  endproperty
  a_peak_scale: assert property (p_peak_scale)
    else $error("peak current not 25mA per step");

  property p_vout_scale;
    ##1 output_voltage_mv ==
      `R2C_VOUT_BASE_MV + 13'(output_voltage_code) * 13'($past(voltage_step_size));
  endproperty
  a_vout_scale: assert property (p_vout_scale)
    else $error("output voltage not base plus code times step");

  property p_vset_used;
    !pair_bus.active |=> output_voltage_code == $past(output_voltage_setpoint_ff);
  endproperty
  a_vset_used: assert property (p_vset_used)
    else $error("setpoint code not applied");

  property p_mask_gate;
    !(by_source && src_pins) |=>
      !pin_mask_active && (regulator_enable == $past(on_by_source));
  endproperty
  a_mask_gate: assert property (p_mask_gate)
    else $error("pin mask acted outside slot 111 and source 10");

  property p_pin_or;
    mask_apply && ((pin_enable_mask_ff & pin_sync_ff) != 8'h00) |=> regulator_enable;
  endproperty
  a_pin_or: assert property (p_pin_or)
    else $error("selected pin high but regulator off");

  property p_unmasked_pins;
    mask_apply && ((pin_enable_mask_ff & pin_sync_ff) == 8'h00) |=> !regulator_enable;
  endproperty
  a_unmasked_pins: assert property (p_unmasked_pins)
    else $error("unselected pin enabled regulator");

  property p_source_on;
    by_source && src_on |=> regulator_enable ##0 !pin_mask_active;
  endproperty
  a_source_on: assert property (p_source_on)
    else $error("source 01 after boot did not enable");

  property p_scaling_off;
    scaling_pin_pair_select_ff == `R2C_PAIR_OFF |=> !dynamic_voltage_scaling;
  endproperty
  a_scaling_off: assert property (p_scaling_off)
    else $error("scaling active with selector zero");

  property p_pair_01;
    scaling_pin_pair_select_ff == 5'h01 |=>
      dynamic_voltage_scaling && scaling_pair_state == $past(pins_01);
  endproperty
  a_pair_01: assert property (p_pair_01)
    else $error("code 00001 not pins 0 and 1");

  property p_pair_12;
    scaling_pin_pair_select_ff == 5'h08 |=>
      dynamic_voltage_scaling && scaling_pair_state == $past(pins_12);
  endproperty
  a_pair_12: assert property (p_pair_12)
    else $error("code 01000 not pins 1 and 2");

  property p_pair_reserved;
    scaling_pin_pair_select_ff > `R2C_PAIR_LAST |=> !dynamic_voltage_scaling;
  endproperty
  a_pair_reserved: assert property (p_pair_reserved)
    else $error("reserved selector enabled scaling");

  property p_alt_select;
    pair_bus.active |=>
      output_voltage_code == $past(alt_now);
  endproperty
  a_alt_select: assert property (p_alt_select)
    else $error("alternate setting not chosen by pair state");

  property p_readback;
    reg_write && hit_vset ##1 reg_read && hit_vset && !reg_write |=>
      reg_rdata == {2'h0, $past(wdata_vset, 2)} && reg_ack;
  endproperty
  a_readback: assert property (p_readback)
    else $error("setpoint readback mismatch");

  property p_pair_state_off;
    !pair_bus.active |=> scaling_pair_state == 2'h0 && !dynamic_voltage_scaling;
  endproperty
  a_pair_state_off: assert property (p_pair_state_off)
    else $error("pair state shown while scaling off");

  property p_enable_off;
    !boot_delay_done |=> !regulator_enable && !pin_mask_active;
  endproperty
  a_enable_off: assert property (p_enable_off)
    else $error("regulator enabled before boot delay elapsed");

  property p_reserved_source;
    enable_source_select == R2C_SRC_RSVD_E |=> !regulator_enable && !pin_mask_active;
  endproperty
  a_reserved_source: assert property (p_reserved_source)
    else $error("reserved enable source turned regulator on");

  c_bypass:   cover property (peak_bypass ##1 peak_current_ma != 9'h000);
  c_scaling:  cover property (dynamic_voltage_scaling && scaling_pair_state == 2'h3);
  c_pin_en:   cover property (pin_mask_active && regulator_enable);
  c_readback: cover property (reg_read && hit_mask ##1 reg_ack);
  c_src_on:   cover property (on_by_source ##1 regulator_enable);
endmodule

// ---- tb/regulator_two_control_regs_bench.sv ----
// Self-checking bench for the regulator two control register group
`timescale 1ns/100ps
module regulator_two_control_regs_bench;
  import r2c_pkg::*;
  logic          clock                     = 1'b0;
  logic          reset                     = 1'b1;
  r2c_byte_type  reg_addr                  = 8'h00;
  logic          reg_write                 = 1'b0;
  logic          reg_read                  = 1'b0;
  r2c_byte_type  reg_wdata                 = 8'h00;
  r2c_byte_type  reg_rdata;
  logic          reg_ack;
  r2c_byte_type  multipurpose_control_pin  = 8'h00;
  logic [2:0]    startup_sequence_slot     = 3'h0;
  r2c_src_type   enable_source_select      = R2C_SRC_OFF_E;
  logic          boot_delay_done           = 1'b0;
  r2c_code4_type lookup_peak_code          = 4'h0;
  r2c_code6_type voltage_step_size         = 6'h19;
  r2c_alt_type   alternate_voltage_setting = '0;
  r2c_code4_type effective_peak_code;
  r2c_ma_type    peak_current_ma;
  r2c_code6_type output_voltage_code;
  r2c_mv_type    output_voltage_mv;
  logic          pin_mask_active;
  logic          regulator_enable;
  logic          dynamic_voltage_scaling;
  logic [1:0]    scaling_pair_state;
  int            n_errors                  = 0;
  int            samples_checked           = 0;
  logic [31:0]   seed                      = 32'h0000_8273;

  always #20 clock = ~clock;

  r2c_ctrl i_r2c_ctrl (.clock(clock), .reset(reset), .reg_addr(reg_addr),
    .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .multipurpose_control_pin(multipurpose_control_pin),
    .startup_sequence_slot(startup_sequence_slot),
    .enable_source_select(enable_source_select), .boot_delay_done(boot_delay_done),
    .lookup_peak_code(lookup_peak_code), .voltage_step_size(voltage_step_size),
    .alternate_voltage_setting(alternate_voltage_setting),
    .effective_peak_code(effective_peak_code), .peak_current_ma(peak_current_ma),
    .output_voltage_code(output_voltage_code), .output_voltage_mv(output_voltage_mv),
    .pin_mask_active(pin_mask_active), .regulator_enable(regulator_enable),
    .dynamic_voltage_scaling(dynamic_voltage_scaling),
    .scaling_pair_state(scaling_pair_state));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Returns {valid, lower pin, higher pin}; pairs enumerate lexicographically
  function automatic logic [6:0] pair_exp(input logic [4:0] code);
    int n;
    n = 0;
    pair_exp = 7'h00;
    for (int lo = 0; lo < 8; lo++) begin
      for (int hi = lo + 1; hi < 8; hi++) begin
        n++;
        if (n == code) pair_exp = {1'b1, 3'(lo), 3'(hi)};
      end
    end
  endfunction

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Strobes rise on one edge and drop on the next, so back-to-back calls never clash
  task automatic access(input logic wr, input logic rd_en, input r2c_byte_type addr,
                        input r2c_byte_type data, output r2c_byte_type rd);
    @(posedge clock);
    reg_addr  <= addr;
    reg_wdata <= data;
    reg_write <= wr;
    reg_read  <= rd_en;
    @(posedge clock);
    reg_write <= 1'b0;
    reg_read  <= 1'b0;
    #1;
    rd = reg_rdata;
    check("reg_ack", reg_ack, 16'h1);
  endtask

  task automatic wr_reg(input r2c_byte_type addr, input r2c_byte_type data);
    r2c_byte_type rd;
    access(1'b1, 1'b0, addr, data, rd);
  endtask

  task automatic rd_chk(input r2c_byte_type addr, input r2c_byte_type exp);
    r2c_byte_type rd;
    access(1'b0, 1'b1, addr, 8'h00, rd);
    check("reg_rdata", rd, exp);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Long enough for all tests several times over
  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    complete_run();
  end

  initial begin
    logic [7:0]  masks [4];
    logic [7:0]  d;
    logic [6:0]  pe;
    logic [5:0]  vs;
    logic [1:0]  st;
    logic        act;
    logic        en;
    r2c_byte_type rd;
    masks = '{8'h8f, 8'h3f, 8'hff, 8'h1f};
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    settle(1);
    check("reg_ack idle", reg_ack, 16'h0);
    check("output_voltage_mv", output_voltage_mv, 16'd550);
    for (int k = 0; k < 5; k++) rd_chk(8'h2a + 8'(k), 8'h00);
    $display("test reset done");

    for (int i = 0; i < 24; i++) begin
      d = 8'(rnd());
      wr_reg(8'h2a + 8'(i % 4), d);
      rd_chk(8'h2a + 8'(i % 4), d & masks[i % 4]);
    end
    wr_reg(8'h29, 8'hff);
    rd_chk(8'h29, 8'h00);
    wr_reg(8'h2c, 8'h5a);
    access(1'b1, 1'b1, 8'h2c, 8'ha5, rd);
    check("read during write", rd, 16'h5a);
    rd_chk(8'h2c, 8'ha5);
    @(posedge clock);
    reg_addr  <= 8'h2b;
    reg_wdata <= 8'h15;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    reg_read  <= 1'b1;
    @(posedge clock);
    reg_read  <= 1'b0;
    #1;
    check("back to back read", reg_rdata, 16'h15);
    $display("test registers done");

    @(posedge clock);
    lookup_peak_code <= 4'(rnd()) & 4'h7;
    wr_reg(8'h2a, 8'h0f);
    settle(2);
    check("effective_peak_code table", effective_peak_code, lookup_peak_code);
    for (int c = 0; c < 16; c++) begin
      wr_reg(8'h2a, {1'b1, 3'(rnd()), 4'(c)});
      settle(2);
      check("effective_peak_code", effective_peak_code, 16'(c));
      check("peak_current_ma", peak_current_ma, 16'(c * 25));
    end
    for (int c = 6; c < 9; c++) begin
      wr_reg(8'h2a, 8'h80 | 8'(c));
      settle(2);
      check("peak_current_ma advised", peak_current_ma, 16'(c * 25));
    end
    $display("test peak current done");

    wr_reg(8'h2d, 8'h00);
    for (int i = 0; i < 12; i++) begin
      vs = (i < 3) ? 6'h3f : 6'(rnd());
      @(posedge clock);
      voltage_step_size <= (i % 3 == 0) ? 6'd10 : (i % 3 == 1) ? 6'd50 : 6'(rnd());
      wr_reg(8'h2b, {2'(rnd()), vs});
      settle(3);
      check("output_voltage_code", output_voltage_code, vs);
      check("output_voltage_mv", output_voltage_mv,
            16'(550 + vs * voltage_step_size));
    end
    $display("test voltage done");

    for (int i = 0; i < 32; i++) begin
      d = 8'(rnd());
      wr_reg(8'h2c, (i < 4) ? (8'h01 << i) : d);
      @(posedge clock);
      startup_sequence_slot    <= (i % 4 != 3) ? 3'h7 : 3'(rnd());
      boot_delay_done          <= (i % 4 != 2) ? 1'b1 : 1'b0;
      enable_source_select     <= r2c_src_type'((i % 2 == 0) ? 2'h2 :
                                                (i == 1) ? 2'h1 : 2'(rnd()));
      multipurpose_control_pin <= 8'(rnd());
      settle(5);
      act = startup_sequence_slot == 3'h7 && boot_delay_done
            && enable_source_select == R2C_SRC_PIN_E;
      en  = (act && |((i < 4 ? (8'h01 << i) : d) & multipurpose_control_pin))
            || (startup_sequence_slot == 3'h7 && boot_delay_done
                && enable_source_select == R2C_SRC_ON_E);
      check("pin_mask_active", pin_mask_active, act);
      check("regulator_enable", regulator_enable, en);
    end
    $display("test pin enable done");

    @(posedge clock);
    for (int k = 0; k < 4; k++) alternate_voltage_setting[k] <= 6'(rnd());
    wr_reg(8'h2b, 8'h2b);
    for (int c = 0; c < 64; c++) begin
      wr_reg(8'h2d, {3'(rnd()), 5'(c / 2)});
      @(posedge clock);
      multipurpose_control_pin <= 8'(rnd());
      settle(5);
      pe = pair_exp(5'(c / 2));
      st = pe[6] ? {multipurpose_control_pin[pe[5:3]], multipurpose_control_pin[pe[2:0]]} : 2'h0;
      check("dynamic_voltage_scaling", dynamic_voltage_scaling, pe[6]);
      check("scaling_pair_state", scaling_pair_state, st);
      check("output_voltage_code dvs", output_voltage_code,
            pe[6] ? alternate_voltage_setting[st] : 6'h2b);
    end
    $display("test pin pairs done");
    complete_run();
  end
endmodule
